/* File: verilog/flp_pkg.sv */
package flp_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_FREQ_HZ      = 25_000_000;
  localparam int MIN_PULSE_NS     = 2000;
  localparam int CLK_PERIOD_NS    = 1_000_000_000 / CLK_FREQ_HZ;
  // Least time: round up
  localparam int MIN_PULSE_CYC    =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W           = 6;
  localparam logic [FILT_W-1:0] FILT_DONE =
    FILT_W'(MIN_PULSE_CYC);

  // ==========================================================
  // Consecutive drive pulse count
  // ==========================================================
  localparam int CNT_W            = 3;
  localparam logic [CNT_W-1:0] LATCH_COUNT = 3'h4;
  localparam logic [CNT_W-1:0] CNT_RESET   = 3'h0;

  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [2:0] {
    FLP_OFF     = 3'b000,
    FLP_SSTART  = 3'b001,
    FLP_RUN     = 3'b010,
    FLP_LATCHED = 3'b011,
    FLP_TSD     = 3'b100
  } flp_state_t;

endpackage : flp_pkg

/* File: verilog/flp_fault_latch.sv */
`timescale 1ns/1ps
`default_nettype none

module flp_fault_latch
  import flp_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic vcc_on,
  input  wire logic vcc_reset,
  input  wire logic soft_start_done,
  input  wire logic brownout_enabled,
  input  wire logic brownout_not_ok,
  input  wire logic upper_fault_level,
  input  wire logic lower_fault_level,
  input  wire logic fault_input_enable_level,
  input  wire logic thermal_trip_level,
  input  wire logic thermal_trip_hysteresis,
  input  wire logic drive_clock,
  output logic      drive_enable,
  output logic      hiccup_request,
  output logic      thermistor_bias_source,
  output logic      fault_input_active,
  output logic      fault_latched,
  output logic      thermal_shutdown
);
  import flp_pkg::*;

  // ==========================================================
  // Reset release and input synchronisers
  // ==========================================================
  localparam int NIN = 11;
  logic [1:0]     rst_sync_q;
  logic           rst_int_n;
  logic [NIN-1:0] in_raw;
  logic [NIN-1:0] meta_q;
  logic [NIN-1:0] sync_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  assign in_raw = {vcc_on, vcc_reset, soft_start_done, brownout_enabled,
                   brownout_not_ok, upper_fault_level, lower_fault_level,
                   fault_input_enable_level, thermal_trip_level,
                   thermal_trip_hysteresis, drive_clock};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else if (clk_en) begin
          meta_q[gi] <= in_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic s_vcc_on, s_vcc_rst, s_ss_done, s_bo_en, s_brownout_not_ok;
  logic s_upper, s_lower, s_en_lvl, s_hot, s_cool, s_drv;
  assign {s_vcc_on, s_vcc_rst, s_ss_done, s_bo_en, s_brownout_not_ok, s_upper,
          s_lower, s_en_lvl, s_hot, s_cool, s_drv} = sync_q;

  // ==========================================================
  // Start event, drive pulse edge
  // ==========================================================
  logic vcc_on_q, drv_q;
  logic start_evt, drv_rise, release_evt;

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      vcc_on_q <= 1'b0;
      drv_q    <= 1'b0;
    end else if (clk_en) begin
      vcc_on_q <= s_vcc_on;
      drv_q    <= s_drv;
    end
  end
  assign start_evt = s_vcc_on && !vcc_on_q;
  assign drv_rise  = s_drv && !drv_q;
  // Brown-out release only when that sensing is on
  assign release_evt = s_bo_en ? (s_brownout_not_ok || s_vcc_rst) : s_vcc_rst;

  // ==========================================================
  // Sequencer state
  // ==========================================================
  flp_state_t state_q;
  logic       fin_en_q;
  logic       fault_evt, latch_req, ot_mask;
  logic [CNT_W-1:0] cnt_q;

  // Fault pin sampled at the start crossing
  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      fin_en_q <= 1'b0;
    end else if (clk_en) begin
      if (s_vcc_rst) begin
        fin_en_q <= 1'b0;
      end else if (start_evt) begin
        fin_en_q <= s_en_lvl;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_q <= FLP_OFF;
    end else if (clk_en) begin
      unique case (state_q)
        FLP_OFF: begin
          if (start_evt && !s_hot) begin
            state_q <= FLP_SSTART;
          end
        end
        FLP_SSTART, FLP_RUN: begin
          if (s_vcc_rst) begin
            state_q <= FLP_OFF;
          end else if (s_hot) begin
            state_q <= FLP_TSD;
          end else if (latch_req) begin
            state_q <= FLP_LATCHED;
          end else if (state_q == FLP_SSTART && s_ss_done) begin
            state_q <= FLP_RUN;
          end
        end
        FLP_LATCHED: begin
          if (release_evt) begin
            state_q <= FLP_OFF;
          end
        end
        FLP_TSD: begin
          if (s_vcc_rst) begin
            state_q <= FLP_OFF;
          end else if (start_evt && s_cool && !s_hot) begin
            state_q <= FLP_SSTART;
          end
        end
        default: state_q <= FLP_OFF;
      endcase
    end
  end

  // ==========================================================
  // Minimum width filters
  // ==========================================================
  logic [FILT_W-1:0] ov_cnt_q, ot_cnt_q;
  logic              ov_valid, ot_valid;

  assign ot_mask = (state_q == FLP_SSTART);

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ov_cnt_q <= '0;
    end else if (clk_en) begin
      if (!s_upper || !fin_en_q) begin
        ov_cnt_q <= '0;
      end else if (ov_cnt_q != FILT_DONE) begin
        ov_cnt_q <= ov_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ot_cnt_q <= '0;
    end else if (clk_en) begin
      if (!s_lower || !fin_en_q || ot_mask) begin
        ot_cnt_q <= '0;
      end else if (ot_cnt_q != FILT_DONE) begin
        ot_cnt_q <= ot_cnt_q + 1'b1;
      end
    end
  end

  assign ov_valid  = (ov_cnt_q == FILT_DONE);
  assign ot_valid  = (ot_cnt_q == FILT_DONE);
  assign fault_evt = fin_en_q && (ov_valid || ot_valid);

  // ==========================================================
  // Consecutive drive pulse counter
  // ==========================================================
  logic running;
  assign running = (state_q == FLP_SSTART) || (state_q == FLP_RUN);

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cnt_q <= CNT_RESET;
    end else if (clk_en) begin
      if (s_vcc_rst || !running) begin
        cnt_q <= CNT_RESET;
      end else if (drv_rise) begin
        if (fault_evt) begin
          cnt_q <= cnt_q + 1'b1;
        end else begin
          cnt_q <= CNT_RESET;
        end
      end
    end
  end
  assign latch_req = drv_rise && fault_evt &&
                     (cnt_q == LATCH_COUNT - 3'h1);

  // ==========================================================
  // Outputs
  // ==========================================================
  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      thermistor_bias_source <= 1'b0;
    end else if (clk_en) begin
      if (s_vcc_rst) begin
        thermistor_bias_source <= 1'b0;
      end else if (start_evt) begin
        thermistor_bias_source <= 1'b1;
      end
    end
  end

  // Drive stops in the same cycle the latch decision is made
  assign drive_enable   = running && !latch_req && !s_hot;
  assign hiccup_request = (state_q == FLP_LATCHED) ||
                          (state_q == FLP_TSD);
  assign fault_latched      = (state_q == FLP_LATCHED);
  assign thermal_shutdown   = (state_q == FLP_TSD);
  assign fault_input_active = fin_en_q;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_int_n);

  latch_stops_drive_a: assert property (fault_latched |-> !drive_enable)
    else $error("drive active while latched");
  latch_on_fourth_a: assert property (
    clk_en && latch_req && !s_vcc_rst && !s_hot && running
    |=> fault_latched)
    else $error("fourth faulted pulse did not latch");
  latch_needs_count_a: assert property (
    $rose(fault_latched) |-> $past(cnt_q) == LATCH_COUNT - 3'h1)
    else $error("latched without full count");
  disabled_no_latch_a: assert property (
    !fin_en_q |-> cnt_q == CNT_RESET)
    else $error("counter moved with fault input off");
  ot_masked_ss_a: assert property (ot_mask |=> ot_cnt_q == '0)
    else $error("lower comparator seen in soft-start");
  filter_width_a: assert property (
    $rose(ov_valid) |-> $past(s_upper, MIN_PULSE_CYC))
    else $error("short pulse validated");
  latch_release_a: assert property (
    clk_en && fault_latched && release_evt |=> state_q == FLP_OFF)
    else $error("latch not released");
  tsd_hiccup_a: assert property (
    thermal_shutdown |-> hiccup_request && !drive_enable)
    else $error("thermal shutdown without hiccup");
  tsd_vcc_clear_a: assert property (
    clk_en && thermal_shutdown && s_vcc_rst |=> state_q == FLP_OFF)
    else $error("supply reset left thermal shutdown");
  bias_off_a: assert property (
    state_q == FLP_OFF && !vcc_on_q |-> !thermistor_bias_source ||
    $past(thermistor_bias_source))
    else $error("bias source on before start");

  latch_cov_c: cover property ($rose(fault_latched));
  tsd_cov_c: cover property ($rose(thermal_shutdown));
  release_cov_c: cover property (fault_latched ##1 state_q == FLP_OFF);
  disabled_cov_c: cover property (start_evt && !s_en_lvl);

endmodule : flp_fault_latch

`default_nettype wire

/* File: test/flp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Fault pin network and power stage
// ==========================================================
module flp_pin_model (
  input  wire logic clock,
  input  wire logic drive_enable,
  input  wire logic bias_on,
  input  wire logic zener_on,
  input  wire logic ntc_hot,
  input  wire logic pin_grounded,
  output logic      upper_fault_level,
  output logic      lower_fault_level,
  output logic      fault_input_enable_level,
  output logic      drive_clock
);
  logic [1:0] phase_q;

  // Zener lifts pin over the upper level
  assign upper_fault_level = zener_on & ~pin_grounded;
  // Unbiased or hot thermistor leaves pin low
  assign lower_fault_level = pin_grounded | ntc_hot | ~bias_on;
  assign fault_input_enable_level = ~pin_grounded;

  // Gate pulses, period 8 cycles, only while drive enabled
  always_ff @(posedge clock) begin
    if (!drive_enable) begin
      phase_q     <= 2'h0;
      drive_clock <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3) begin
        drive_clock <= ~drive_clock;
      end
    end
  end
endmodule : flp_pin_model
`default_nettype wire

/* File: test/flp_fault_latch_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flp_fault_latch_tb;
  import flp_pkg::*;
  logic clock, rst_n, clk_en, vcc_on, vcc_reset, soft_start_done;
  logic brownout_enabled, brownout_not_ok, thermal_trip_level;
  logic thermal_trip_hysteresis, zener_on, ntc_hot, pin_grounded;
  logic upper_fault_level, lower_fault_level, fault_input_enable_level;
  logic drive_clock, drive_enable, hiccup_request, thermistor_bias_source;
  logic fault_input_active, fault_latched, thermal_shutdown;
  int   num_errors = 0;
  int   comparisons = 0;
  int   n;

  flp_fault_latch dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .vcc_on(vcc_on), .vcc_reset(vcc_reset),
    .soft_start_done(soft_start_done),
    .brownout_enabled(brownout_enabled), .brownout_not_ok(brownout_not_ok),
    .upper_fault_level(upper_fault_level),
    .lower_fault_level(lower_fault_level),
    .fault_input_enable_level(fault_input_enable_level),
    .thermal_trip_level(thermal_trip_level),
    .thermal_trip_hysteresis(thermal_trip_hysteresis),
    .drive_clock(drive_clock), .drive_enable(drive_enable),
    .hiccup_request(hiccup_request),
    .thermistor_bias_source(thermistor_bias_source),
    .fault_input_active(fault_input_active),
    .fault_latched(fault_latched), .thermal_shutdown(thermal_shutdown));

  flp_pin_model u_pin (.clock(clock), .drive_enable(drive_enable),
    .bias_on(thermistor_bias_source), .zener_on(zener_on),
    .ntc_hot(ntc_hot), .pin_grounded(pin_grounded),
    .upper_fault_level(upper_fault_level),
    .lower_fault_level(lower_fault_level),
    .fault_input_enable_level(fault_input_enable_level),
    .drive_clock(drive_clock));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task check(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: saw %b, expected %b", $time, seen, exp);
    end
  endtask : check

  task tick(input int c);
    repeat (c) @(posedge clock);
  endtask : tick

  task finish_test;
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task power_up(input logic ss);
    vcc_reset <= 1'b0;
    vcc_on    <= 1'b1;
    tick(12);
    soft_start_done <= ss;
    tick(4);
  endtask : power_up

  task power_down;
    vcc_on          <= 1'b0;
    soft_start_done <= 1'b0;
    vcc_reset       <= 1'b1;
    tick(10);
    vcc_reset <= 1'b0;
    tick(4);
  endtask : power_down

  task vcc_cycle;
    vcc_on <= 1'b0;
    tick(10);
    vcc_on <= 1'b1;
    tick(12);
  endtask : vcc_cycle

  task wait_latch;
    for (n = 0; n < 300 && fault_latched !== 1'b1; n++) tick(1);
  endtask : wait_latch

  task pulse(input int on_c, input int off_c);
    zener_on <= 1'b1;
    tick(on_c);
    zener_on <= 1'b0;
    tick(off_c);
  endtask : pulse

  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_overvoltage;
    power_up(1'b1);
    check(fault_input_active, 1'b1);
    check(thermistor_bias_source, 1'b1);
    pulse(40, 100);
    check(fault_latched, 1'b0);
    pulse(70, 30);
    pulse(70, 30);
    check(fault_latched, 1'b0);
    zener_on <= 1'b1;
    wait_latch();
    check(n >= 76 && n <= 140, 1'b1);
    check(fault_latched, 1'b1);
    check(drive_enable, 1'b0);
    check(hiccup_request, 1'b1);
    zener_on <= 1'b0;
    vcc_cycle();
    check(fault_latched, 1'b1);
    brownout_not_ok <= 1'b1;
    tick(8);
    check(fault_latched, 1'b1);
    brownout_not_ok <= 1'b0;
    power_down();
    check(fault_latched, 1'b0);
    check(thermistor_bias_source, 1'b0);
    $display("Test overvoltage done");
  endtask : t_overvoltage

  task t_overtemp;
    brownout_enabled <= 1'b1;
    ntc_hot          <= 1'b1;
    power_up(1'b0);
    tick(200);
    check(fault_latched, 1'b0);
    soft_start_done <= 1'b1;
    wait_latch();
    check(fault_latched, 1'b1);
    ntc_hot         <= 1'b0;
    brownout_not_ok <= 1'b1;
    tick(8);
    check(fault_latched, 1'b0);
    brownout_not_ok <= 1'b0;
    power_down();
    brownout_enabled <= 1'b0;
    $display("Test overtemperature done");
  endtask : t_overtemp

  task t_disabled;
    pin_grounded <= 1'b1;
    power_up(1'b1);
    check(fault_input_active, 1'b0);
    tick(300);
    check(fault_latched, 1'b0);
    pin_grounded <= 1'b0;
    zener_on     <= 1'b1;
    tick(300);
    check(fault_latched, 1'b0);
    check(drive_enable, 1'b1);
    zener_on <= 1'b0;
    power_down();
    $display("Test disabled input done");
  endtask : t_disabled

  task t_thermal;
    power_up(1'b1);
    thermal_trip_level <= 1'b1;
    tick(8);
    check(thermal_shutdown, 1'b1);
    check(drive_enable, 1'b0);
    check(hiccup_request, 1'b1);
    thermal_trip_level <= 1'b0;
    vcc_cycle();
    check(thermal_shutdown, 1'b1);
    thermal_trip_hysteresis <= 1'b1;
    vcc_cycle();
    check(thermal_shutdown, 1'b0);
    check(drive_enable, 1'b1);
    thermal_trip_level <= 1'b1;
    tick(8);
    thermal_trip_level      <= 1'b0;
    thermal_trip_hysteresis <= 1'b0;
    vcc_on                  <= 1'b0;
    tick(8);
    check(thermal_shutdown, 1'b1);
    clk_en    <= 1'b0;
    vcc_reset <= 1'b1;
    tick(8);
    check(thermal_shutdown, 1'b1);
    clk_en <= 1'b1;
    tick(8);
    check(thermal_shutdown, 1'b0);
    power_down();
    $display("Test thermal done");
  endtask : t_thermal

  initial begin
    {rst_n, vcc_on, vcc_reset, soft_start_done, brownout_enabled} = '0;
    {brownout_not_ok, thermal_trip_level, thermal_trip_hysteresis} = '0;
    {zener_on, ntc_hot, pin_grounded} = '0;
    clk_en = 1'b1;
    tick(8);
    rst_n <= 1'b1;
    tick(12);
    t_overvoltage();
    t_overtemp();
    t_disabled();
    t_thermal();
    finish_test();
  end

  initial begin
    tick(20000);
    num_errors++;
    finish_test();
  end
endmodule : flp_fault_latch_tb
`default_nettype wire
